// ==== rtl/dpir_router.sv ====
// Interrupt router: 19 sources steered to a normal or a fast request line
//
// Function
// - Positions: external 0-7, reserved 8-9, peripherals 10-19, software 20.
// - Watchdog 10, serial ports 11-12, converter 13, timers 14-19.
// - Each source but software configurable; default detection is falling edge.
// - No hardware priority or vectors; software uses path masks.
// - Global mask bits 0-19: 1 blocks a source; 0 lets it through.
// - Masking a source globally clears its status bit.
// - Global mask resets to all ones.
// - Trigger kind: 0 edge, 1 level; resets to 0.
// - Trigger sense: 0 falling/low, 1 rising/high; resets to 0.
// - Per-source direction selects normal or fast request path.
// - Separate path status registers; clear by writing 1, edge sources only.
// - Per-path request masks gate requests to the processor.
// - Global mask bit 20 written 1 raises software request, 0 withdraws.
// - Software source is level sensitive, active high, ignoring triggers.
// - Registers at 0x1200, 0x1204, 0x1208, 0x120C, clear at 0x1220.
// - Direction 0 routes to normal path, 1 to fast; resets 0.
// - Path masks: 0 allows, 1 blocks; reset to 0.
// - Clear writes act only on bits written as 1.
`timescale 1ns/1ps
`default_nettype none

module dpir_router (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [dpir_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpir_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpir_pkg::DATA_W-1:0] reg_rdata,
  // Interrupt sources
  input wire logic [dpir_pkg::NUM_EXT-1:0] ext_source,
  input wire logic watchdog_source,
  input wire logic serial0_source,
  input wire logic serial1_source,
  input wire logic converter_source,
  input wire logic [dpir_pkg::NUM_TIMERS-1:0] timer_source,
  // Processor requests, active high
  output logic normal_req,
  output logic fast_req
);

  typedef struct packed {
    logic [dpir_pkg::SRC_W-1:0] sync1;
    logic [dpir_pkg::SRC_W-1:0] sync2;
    logic [dpir_pkg::SRC_W-1:0] sync3;
    logic [dpir_pkg::SRC_W-1:0] filt;
    logic [dpir_pkg::SRC_W-1:0] global_source_mask;
    logic [dpir_pkg::SRC_W-1:0] trigger_kind_select;
    logic [dpir_pkg::SRC_W-1:0] trigger_sense_select;
    logic [dpir_pkg::SRC_W-1:0] path_route_select;
    logic [dpir_pkg::SRC_W-1:0] fast_request_mask;
    logic [dpir_pkg::SRC_W-1:0] normal_request_mask;
    logic [dpir_pkg::SRC_W-1:0] status;
    logic [dpir_pkg::DATA_W-1:0] rdata;
    logic normal_req;
    logic fast_req;
  } dpir_state_t;

  dpir_state_t st;
  dpir_state_t next_st;
  logic [dpir_pkg::SRC_W-1:0] raw_src;

  // Gather sources onto their fixed positions; reserved stay low
  always_comb begin
    raw_src = dpir_pkg::ZERO_SRC;
    raw_src[dpir_pkg::POS_EXT_LO +: dpir_pkg::NUM_EXT] = ext_source;
    raw_src[dpir_pkg::POS_WATCHDOG] = watchdog_source;
    raw_src[dpir_pkg::POS_SERIAL0] = serial0_source;
    raw_src[dpir_pkg::POS_SERIAL1] = serial1_source;
    raw_src[dpir_pkg::POS_CONVERTER] = converter_source;
    raw_src[dpir_pkg::POS_TIMER_LO +: dpir_pkg::NUM_TIMERS] =
      timer_source;
  end

  logic [dpir_pkg::SRC_W-1:0] agree;
  logic [dpir_pkg::SRC_W-1:0] new_filt;
  logic [dpir_pkg::SRC_W-1:0] rise;
  logic [dpir_pkg::SRC_W-1:0] fall;
  logic [dpir_pkg::SRC_W-1:0] edge_hit;
  logic [dpir_pkg::SRC_W-1:0] level_on;
  logic [dpir_pkg::SRC_W-1:0] clr_mask;
  logic [dpir_pkg::SRC_W-1:0] held;
  logic [dpir_pkg::SRC_W-1:0] wr_bits;
  logic wr_gmask;
  logic wr_clear;

  always_comb begin
    next_st = st;
    wr_bits = reg_wdata[dpir_pkg::SRC_W-1:0];
    wr_gmask = reg_wr && (reg_addr == dpir_pkg::OFS_GLOBAL_SOURCE_MASK);
    wr_clear = reg_wr && (reg_addr == dpir_pkg::OFS_PENDING_CLEAR);

    // Three-stage synchroniser; filtered value moves once stages 2 and 3 agree
    next_st.sync1 = raw_src;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree = ~(st.sync2 ^ st.sync3);
    new_filt = (agree & st.sync3) | (~agree & st.filt);
    next_st.filt = new_filt;

    // Detection per trigger kind and sense
    rise = new_filt & ~st.filt;
    fall = ~new_filt & st.filt;
    edge_hit = (st.trigger_sense_select & rise) |
               (~st.trigger_sense_select & fall);
    level_on = (st.trigger_sense_select & new_filt) |
               (~st.trigger_sense_select & ~new_filt);

    // Clear acts on written ones of edge sources only
    clr_mask = wr_clear ? (wr_bits & ~st.trigger_kind_select) :
                          dpir_pkg::ZERO_SRC;

    // Edge status is sticky; a new edge beats a clear in the same cycle
    held = (st.status & ~clr_mask) | edge_hit;
    next_st.status = (st.trigger_kind_select & level_on) |
                     (~st.trigger_kind_select & held);
    // Software source: level high from global mask bit 20 itself
    next_st.status[dpir_pkg::POS_SOFTWARE] =
      st.global_source_mask[dpir_pkg::POS_SOFTWARE];
    // Globally masked positions other than software, and unimplemented ones, hold no status
    next_st.status = next_st.status & dpir_pkg::IMPL_MASK &
      (~st.global_source_mask | dpir_pkg::SW_BIT);

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        dpir_pkg::OFS_GLOBAL_SOURCE_MASK:
          next_st.global_source_mask = wr_bits;
        dpir_pkg::OFS_TRIGGER_KIND_SELECT:
          next_st.trigger_kind_select = wr_bits;
        dpir_pkg::OFS_TRIGGER_SENSE_SELECT:
          next_st.trigger_sense_select = wr_bits;
        dpir_pkg::OFS_PATH_ROUTE_SELECT:
          next_st.path_route_select = wr_bits;
        dpir_pkg::OFS_FAST_REQUEST_MASK:
          next_st.fast_request_mask = wr_bits;
        dpir_pkg::OFS_NORMAL_REQUEST_MASK:
          next_st.normal_request_mask = wr_bits;
        default: begin
        end
      endcase
    end
    // Mask takes effect on status the cycle the write lands
    if (wr_gmask) begin
      next_st.status = next_st.status &
        (~wr_bits | dpir_pkg::SW_BIT);
      next_st.status[dpir_pkg::POS_SOFTWARE] =
        wr_bits[dpir_pkg::POS_SOFTWARE];
    end

    // Read data stands in the cycle after the strobe only
    next_st.rdata = dpir_pkg::ZERO_DATA;
    if (reg_rd) begin
      unique case (reg_addr)
        dpir_pkg::OFS_GLOBAL_SOURCE_MASK:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.global_source_mask;
        dpir_pkg::OFS_TRIGGER_KIND_SELECT:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.trigger_kind_select;
        dpir_pkg::OFS_TRIGGER_SENSE_SELECT:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.trigger_sense_select;
        dpir_pkg::OFS_PATH_ROUTE_SELECT:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.path_route_select;
        dpir_pkg::OFS_FAST_PATH_PENDING:
          next_st.rdata[dpir_pkg::SRC_W-1:0] =
            st.status & st.path_route_select;
        dpir_pkg::OFS_NORMAL_PATH_PENDING:
          next_st.rdata[dpir_pkg::SRC_W-1:0] =
            st.status & ~st.path_route_select;
        dpir_pkg::OFS_FAST_REQUEST_MASK:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.fast_request_mask;
        dpir_pkg::OFS_NORMAL_REQUEST_MASK:
          next_st.rdata[dpir_pkg::SRC_W-1:0] = st.normal_request_mask;
        default: begin
        end
      endcase
    end

    // Plain OR per path: no priority, no vector, software orders service
    next_st.fast_req = |(st.status & st.path_route_select &
                         ~st.fast_request_mask);
    next_st.normal_req = |(st.status & ~st.path_route_select &
                           ~st.normal_request_mask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.global_source_mask <= dpir_pkg::RST_GLOBAL_SOURCE_MASK;
      st.trigger_kind_select <= dpir_pkg::RST_TRIGGER_KIND;
      st.trigger_sense_select <= dpir_pkg::RST_TRIGGER_SENSE;
      st.path_route_select <= dpir_pkg::RST_PATH_ROUTE;
      st.fast_request_mask <= dpir_pkg::RST_REQUEST_MASK;
      st.normal_request_mask <= dpir_pkg::RST_REQUEST_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign normal_req = st.normal_req;
  assign fast_req = st.fast_req;

endmodule // dpir_router

`default_nettype wire

// ==== rtl/dpir_pkg.sv ====
// Constants and register map for the dual path interrupt router
package dpir_pkg;

  localparam int unsigned SRC_W = 21;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 16;

  // Source positions
  localparam int unsigned POS_EXT_LO = 0;
  localparam int unsigned NUM_EXT = 8;
  localparam int unsigned POS_WATCHDOG = 10;
  localparam int unsigned POS_SERIAL0 = 11;
  localparam int unsigned POS_SERIAL1 = 12;
  localparam int unsigned POS_CONVERTER = 13;
  localparam int unsigned POS_TIMER_LO = 14;
  localparam int unsigned NUM_TIMERS = 6;
  localparam int unsigned POS_SOFTWARE = 20;

  // Implemented positions; 8 and 9 are reserved
  localparam logic [SRC_W-1:0] IMPL_MASK = 21'h1FFCFF;
  localparam logic [SRC_W-1:0] SW_BIT = 21'h100000;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_SOURCE_MASK = 16'h1200;
  localparam logic [ADDR_W-1:0] OFS_TRIGGER_KIND_SELECT = 16'h1204;
  localparam logic [ADDR_W-1:0] OFS_TRIGGER_SENSE_SELECT = 16'h1208;
  localparam logic [ADDR_W-1:0] OFS_PATH_ROUTE_SELECT = 16'h120C;
  localparam logic [ADDR_W-1:0] OFS_FAST_PATH_PENDING = 16'h1210;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_PATH_PENDING = 16'h1214;
  localparam logic [ADDR_W-1:0] OFS_FAST_REQUEST_MASK = 16'h1218;
  localparam logic [ADDR_W-1:0] OFS_NORMAL_REQUEST_MASK = 16'h121C;
  localparam logic [ADDR_W-1:0] OFS_PENDING_CLEAR = 16'h1220;

  // Reset values
  localparam logic [SRC_W-1:0] RST_GLOBAL_SOURCE_MASK = 21'h1FFFFF;
  localparam logic [SRC_W-1:0] RST_TRIGGER_KIND = 21'h000000;
  localparam logic [SRC_W-1:0] RST_TRIGGER_SENSE = 21'h000000;
  localparam logic [SRC_W-1:0] RST_PATH_ROUTE = 21'h000000;
  localparam logic [SRC_W-1:0] RST_REQUEST_MASK = 21'h000000;
  localparam logic [SRC_W-1:0] ZERO_SRC = 21'h000000;
  localparam logic [DATA_W-1:0] ZERO_DATA = 32'h00000000;

endpackage : dpir_pkg

// ==== testbench/dpir_core_model.sv ====
// Processor side model that takes normal and fast requests
`timescale 1ns/1ps
`default_nettype none
module dpir_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Requests from the router
  input wire logic normal_req,
  input wire logic fast_req,
  // Counts of requests taken
  output logic [7:0] normal_taken,
  output logic [7:0] fast_taken
);
  logic [1:0] last;
  // Requests are levels; only a new rise is a fresh entry
  always_ff @(posedge core_clk) begin
    last <= rst ? 2'h0 : {fast_req, normal_req};
    normal_taken <= rst ? 8'h00 : normal_taken + 8'(normal_req & ~last[0]);
    fast_taken <= rst ? 8'h00 : fast_taken + 8'(fast_req & ~last[1]);
  end
endmodule // dpir_core_model
`default_nettype wire

// ==== testbench/dpir_router_sva.sv ====
// Port checker for the dual path interrupt router
`timescale 1ns/1ps
`default_nettype none
module dpir_router_sva (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [dpir_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpir_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dpir_pkg::DATA_W-1:0] reg_rdata,
  // Processor requests
  input wire logic normal_req,
  input wire logic fast_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data not idle");
  chk_upper_zero: assert property (reg_rdata[31:21] == 11'h000)
    else $error("unused read bits set");
  chk_wo_unmapped: assert property ($past(reg_rd) &&
    $past(reg_addr) >= 16'h1220 |-> reg_rdata == 0)
    else $error("clear or unmapped read not zero");
  chk_reset_quiet: assert property ($fell(rst) |-> !normal_req && !fast_req)
    else $error("request after reset");
  chk_gmask_clears: assert property (reg_wr && reg_addr == 16'h1200 &&
    reg_wdata[20:0] == 21'h0FFFFF |-> ##2 !normal_req && !fast_req)
    else $error("masked sources still request");
  chk_nmask_blocks: assert property (reg_wr && reg_addr == 16'h121C &&
    reg_wdata[20:0] == 21'h1FFFFF |-> ##2 !normal_req)
    else $error("normal mask ignored");
  chk_fmask_blocks: assert property (reg_wr && reg_addr == 16'h1218 &&
    reg_wdata[20:0] == 21'h1FFFFF |-> ##2 !fast_req)
    else $error("fast mask ignored");
  chk_route_fast: assert property (reg_wr && reg_addr == 16'h120C &&
    reg_wdata[20:0] == 21'h1FFFFF |-> ##2 !normal_req)
    else $error("fast routed source on normal line");
endmodule // dpir_router_sva
bind dpir_router dpir_router_sva u_sva (.core_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .normal_req, .fast_req);
`default_nettype wire

// ==== testbench/dpir_router_tb.sv ====
// Self-checking bench for the dual path interrupt router
`timescale 1ns/1ps
`default_nettype none
module dpir_router_tb;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, normal_req, fast_req;
  logic [15:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, v;
  logic [20:0] src = 0, b;
  logic [7:0] n_cnt, n_base, f_cnt, f_base;
  int mismatches = 0, samples_checked = 0, seed = 6474, p, m;
  int rw[6] = '{0, 1, 2, 3, 6, 7};
  always #12.5 core_clk = ~core_clk;
  dpir_router u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_source(src[7:0]), .watchdog_source(src[10]),
    .serial0_source(src[11]), .serial1_source(src[12]),
    .converter_source(src[13]), .timer_source(src[19:14]), .normal_req,
    .fast_req);
  dpir_core_model u_core (.core_clk, .rst, .normal_req, .fast_req,
    .normal_taken(n_cnt), .fast_taken(f_cnt));
  task automatic chk(logic [31:0] e, logic [31:0] s, string n);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [20:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= {11'h000, d};
    @(posedge core_clk) reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(logic [15:0] a, logic [20:0] e);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk) reg_rd <= 1'h0;
    #1 chk({11'h000, e}, reg_rdata, $sformatf("register %h", a));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Software source idles requesting, so normal path shows bit 20
  function automatic logic [20:0] rst_val(int i);
    return i == 0 ? 21'h1FFFFF : i == 5 ? 21'h100000 : 21'h000000;
  endfunction
  initial begin
    #(25 * 6000);
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    for (int i = 0; i < 10; i++) rd(16'h1200 + 16'(4 * i), rst_val(i));
    chk(32'h1, 32'(normal_req), "normal_req");
    wr(16'h1200, 21'h0FFFFF);
    repeat (3) @(posedge core_clk);
    chk(32'h0, 32'(normal_req), "normal_req");
    foreach (rw[i]) begin
      v = $random(seed);
      wr(16'h1200 + 16'(4 * rw[i]), v[20:0]);
      rd(16'h1200 + 16'(4 * rw[i]), v[20:0]);
    end
    wr(16'h120C, 21'h1FFFFF);
    wr(16'h1218, 21'h1FFFFF);
    wr(16'h121C, 21'h1FFFFF);
    wr(16'h121C, 21'h000000);
    wr(16'h1218, 21'h000000);
    wr(16'h1200, 21'h1FFFFF);
    repeat (3) @(posedge core_clk);
    chk(32'h1, 32'(fast_req), "fast_req");
    rd(16'h1210, 21'h100000);
    wr(16'h1218, 21'h100000);
    repeat (3) @(posedge core_clk);
    chk(32'h0, 32'(fast_req), "fast_req");
    wr(16'h1200, 21'h0FFFFF);
    wr(16'h120C, 21'h000000);
    wr(16'h1218, 21'h000000);
    n_base = n_cnt;
    for (int k = 0; k < 18; k++) begin
      p = k < 8 ? k : k + 2;
      m = k % 4;
      b = 21'h000001 << p;
      src[p] <= ~m[0];
      wr(16'h1204, m[1] ? b : 21'h000000);
      wr(16'h1208, m[0] ? b : 21'h000000);
      wr(16'h1200, 21'h0FFFFF & ~b);
      repeat (6) @(posedge core_clk);
      wr(16'h1220, b);
      rd(16'h1214, 21'h000000);
      src[p] <= m[0];
      repeat (6) @(posedge core_clk);
      rd(16'h1214, b);
      chk(32'h1, 32'(normal_req), "normal_req");
      wr(16'h1220, 21'h1FFFFF & ~b);
      rd(16'h1214, b);
      wr(16'h1220, b);
      rd(16'h1214, m[1] ? b : 21'h000000);
      src[p] <= ~m[0];
      repeat (6) @(posedge core_clk);
      rd(16'h1214, 21'h000000);
      chk(32'h0, 32'(normal_req), "normal_req");
    end
    chk(32'h12, 32'(n_cnt - n_base), "normal entries");
    wr(16'h1208, 21'h000000);
    wr(16'h1200, 21'h0FFFFE);
    src[0] <= 1'h0;
    repeat (6) @(posedge core_clk);
    rd(16'h1214, 21'h000001);
    wr(16'h1200, 21'h0FFFFF);
    rd(16'h1214, 21'h000000);
    // Falling edge on a fast routed source counts one fast entry
    f_base = f_cnt;
    wr(16'h120C, 21'h000001);
    wr(16'h1200, 21'h0FFFFE);
    src[0] <= 1'h1;
    repeat (6) @(posedge core_clk);
    src[0] <= 1'h0;
    repeat (6) @(posedge core_clk);
    rd(16'h1210, 21'h000001);
    rd(16'h1214, 21'h000000);
    chk(32'h1, 32'(fast_req), "fast_req");
    chk(32'h1, 32'(f_cnt - f_base), "fast entries");
    give_verdict;
  end
endmodule // dpir_router_tb
`default_nettype wire
